// ---- exec_pkg.sv ----
// Constants shared by the bit-branch and control execution unit.
// Assumes one synchronous clock domain and an external decoder front end.
package exec_pkg;

    // Operation classes presented to the unit
    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_BIT_SET    = 4'h1,
        OP_BIT_CLEAR  = 4'h2,
        OP_SET_CLEAR  = 4'h3,
        OP_DEC_REG    = 4'h4,
        OP_DEC_MEM    = 4'h5,
        OP_INT_ON     = 4'h6,
        OP_INT_OFF    = 4'h7,
        OP_HALT       = 4'h8,
        OP_STOP       = 4'h9,
        OP_WORD_MOVE  = 4'ha
    } exec_op_e;

    // Bit operand source forms
    typedef enum logic [2:0] {
        SRC_SADDR = 3'h0,
        SRC_SFR   = 3'h1,
        SRC_ACC   = 3'h2,
        SRC_PSW   = 3'h3,
        SRC_HL    = 3'h4
    } bit_src_e;

    // Register pair codes for the word move
    localparam logic [1:0] PAIR_AX = 2'h0;
    localparam logic [1:0] PAIR_BC = 2'h1;
    localparam logic [1:0] PAIR_DE = 2'h2;
    localparam logic [1:0] PAIR_HL = 2'h3;

    // Instruction lengths in bytes
    localparam logic [15:0] LEN_1 = 16'h0001;
    localparam logic [15:0] LEN_2 = 16'h0002;
    localparam logic [15:0] LEN_3 = 16'h0003;
    localparam logic [15:0] LEN_4 = 16'h0004;

    // Status word flag positions
    localparam int PSW_CY_BIT = 0;
    localparam int PSW_AC_BIT = 4;
    localparam int PSW_Z_BIT  = 6;
    localparam int PSW_IE_BIT = 7;

    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam logic [7:0] BYTE_ONE  = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Clock counts, fast region then slow region
    localparam logic [3:0] CLK_2  = 4'h2;
    localparam logic [3:0] CLK_6  = 4'h6;
    localparam logic [3:0] CLK_8  = 4'h8;
    localparam logic [3:0] CLK_9  = 4'h9;
    localparam logic [3:0] CLK_10 = 4'ha;
    localparam logic [3:0] CLK_11 = 4'hb;
    localparam logic [3:0] CLK_12 = 4'hc;

endpackage

// ---- exec_if.sv ----
// Carrier between the execution unit and its cycle timer.
// Assumes both ends share the unit clock.
interface exec_if;
    logic       start;
    logic [3:0] count;
    logic       busy;
    logic       done;
    modport ctrl  (output start, output count, input busy, input done);
    modport timer (input start, input count, output busy, output done);
endinterface

// ---- cycle_timer.sv ----
// Instruction clock counter for the execution unit.
// Assumes a start pulse only while idle.
module cycle_timer (
    // Clock and control
    input  wire logic mclk_i,
    input  wire logic reset_i,
    input  wire logic ce_i,
    // Timer side of carrier
    exec_if.timer     tif
);
    import exec_pkg::*;

    logic [3:0] left_reg;
    logic [3:0] left_next;

    // Count down one per clock, done on the last
    assign left_next = tif.start ? tif.count - 4'h1 :
                       (left_reg != 4'h0) ? left_reg - 4'h1 : left_reg;
    assign tif.busy  = (left_reg != 4'h0);
    assign tif.done  = ce_i && (left_reg == 4'h1);

    // Counter register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            left_reg <= 4'h0;
        end else if (ce_i) begin
            left_reg <= left_next;
        end
    end
endmodule

// ---- bit_branch_exec.sv ----
// Execution unit for bit-test branches, loop decrement, interrupt
// enable and disable, standby entry and the word move destination check.
// Assumes a decoder presents one operation with operands on exec_valid_i
// and the memory side resolves operand bytes before the request.
//

// Notes on behaviour
// - One counted instruction clock equals one enabled mclk_i period.
// - Operand outside fast RAM selects the second, longer cycle count.
// - Branch on bit set: PC gets address, length, displacement; sfr form four bytes.
// - Branch on bit clear only when bit zero; direct, sfr, status forms four bytes.
// - Set-then-clear clears the tested bit and branches; direct form 10 or 12.
// - On status word bit, zero, aux carry and carry follow the new word.
// - Register loop decrements B or C, branches if nonzero; 2 bytes, 6 clocks.
// - Memory loop decrements byte, branches if nonzero; 3 bytes, 8 or 10 clocks.
// - Interrupts-on sets master enable; 2 bytes, 6 clocks.
// - Interrupts-off clears master enable; 2 bytes, 6 clocks.
// - Word move from AX accepted only for BC, DE or HL destination.
module bit_branch_exec (
    // Clock, reset, enable
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    // Request from decoder
    input  wire logic              exec_valid_i,
    input  wire exec_pkg::exec_op_e exec_op_i,
    input  wire exec_pkg::bit_src_e bit_src_i,
    input  wire logic [2:0]        bit_pos_i,
    input  wire logic [15:0]       instr_addr_i,
    input  wire logic [7:0]        relative_displacement_i,
    input  wire logic [7:0]        operand_i,
    input  wire logic              slow_region_i,
    input  wire logic              loop_reg_c_i,
    input  wire logic [1:0]        dest_pair_i,
    // Handshake and results
    output logic                   exec_ready_o,
    output logic                   exec_done_o,
    output logic                   illegal_o,
    output logic [15:0]            pc_o,
    output logic                   operand_we_o,
    output logic [7:0]             operand_o,
    output logic [7:0]             reg_b_o,
    output logic [7:0]             reg_c_o,
    output logic [7:0]             program_status_word_o,
    output logic                   master_interrupt_enable_o,
    output logic                   halt_mode_o,
    output logic                   stop_mode_o,
    output logic                   word_move_accept_o
);
    import exec_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // Helper functions

    // Signed displacement plus length plus base address
    function automatic logic [15:0] branch_target(input logic [15:0] base,
                                                  input logic [15:0] len,
                                                  input logic [7:0]  disp);
        logic [15:0] ext;
        ext = {{8{disp[7]}}, disp};
        branch_target = base + len + ext;
    endfunction

    // Pick fast or slow clock count
    function automatic logic [3:0] pick_count(input logic slow,
                                              input logic [3:0] fast_cnt,
                                              input logic [3:0] slow_cnt);
        pick_count = slow ? slow_cnt : fast_cnt;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // State and storage

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } exec_state_e;

    // Registered state and next values
    exec_state_e state_reg;
    exec_state_e state_next;
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [7:0]  opnd_reg;
    logic [7:0]  opnd_next;
    logic        opnd_we_reg;
    logic        opnd_we_next;
    logic [7:0]  b_reg;
    logic [7:0]  b_next;
    logic [7:0]  c_reg;
    logic [7:0]  c_next;
    logic [7:0]  psw_reg;
    logic [7:0]  psw_next;
    logic        halt_reg;
    logic        halt_next;
    logic        stop_reg;
    logic        stop_next;
    logic        mv_ok_reg;
    logic        mv_ok_next;
    logic        illegal_reg;
    logic        illegal_next;

    // Instruction clock timer
    exec_if tif ();

    cycle_timer u_timer (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .tif     (tif)
    );

    //////////////////////////////////////////////////////////////////////
    // Operand decoding

    // Request accepted this cycle
    wire        take_req   = exec_valid_i && exec_ready_o && ce_i;

    // Tested byte, accumulator from the operand lane
    logic [7:0] reg_a_shadow;
    assign reg_a_shadow = operand_i;
    wire [7:0]  bit_src_byte = (bit_src_i == SRC_ACC) ? reg_a_shadow :
                               (bit_src_i == SRC_PSW) ? psw_reg : operand_i;

    // Tested bit and its cleared byte
    wire        tested_bit = bit_src_byte[bit_pos_i];
    wire [7:0]  bit_mask   = BYTE_ONE << bit_pos_i;
    wire [7:0]  cleared    = bit_src_byte & ~bit_mask;

    // Loop decrement on B, C or the memory byte
    wire [7:0]  loop_src   = loop_reg_c_i ? c_reg : b_reg;
    wire [7:0]  loop_dec   = loop_src - BYTE_ONE;
    wire [7:0]  mem_dec    = operand_i - BYTE_ONE;

    // Branch decisions per operation
    wire        set_taken  = tested_bit;
    wire        clr_taken  = !tested_bit;
    wire        loop_taken = (loop_dec != BYTE_ZERO);
    wire        mem_taken  = (mem_dec != BYTE_ZERO);

    wire [15:0] len_set    = (bit_src_i == SRC_SFR) ? LEN_4 : LEN_3;
    wire [15:0] len_clear  = (bit_src_i == SRC_ACC || bit_src_i == SRC_HL) ? LEN_3 : LEN_4;
    wire [15:0] len_setclr = len_clear;

    logic [3:0] cnt_bit_set;
    logic [3:0] cnt_bit_clr;
    logic [3:0] cnt_set_clr;
    // Branch-if-set counts per form
    always_comb begin
        unique case (bit_src_i)
            SRC_SADDR: cnt_bit_set = pick_count(slow_region_i, CLK_8, CLK_9);
            SRC_SFR:   cnt_bit_set = CLK_11;
            SRC_ACC:   cnt_bit_set = CLK_8;
            SRC_PSW:   cnt_bit_set = CLK_9;
            default:   cnt_bit_set = pick_count(slow_region_i, CLK_10, CLK_11);
        endcase
    end

    // Branch-if-clear counts per form
    always_comb begin
        unique case (bit_src_i)
            SRC_SADDR: cnt_bit_clr = pick_count(slow_region_i, CLK_10, CLK_11);
            SRC_SFR:   cnt_bit_clr = CLK_11;
            SRC_ACC:   cnt_bit_clr = CLK_8;
            SRC_PSW:   cnt_bit_clr = CLK_11;
            default:   cnt_bit_clr = pick_count(slow_region_i, CLK_10, CLK_11);
        endcase
    end

    always_comb begin
        unique case (bit_src_i)
            SRC_SADDR: cnt_set_clr = pick_count(slow_region_i, CLK_10, CLK_12);
            SRC_SFR:   cnt_set_clr = CLK_12;
            SRC_ACC:   cnt_set_clr = CLK_8;
            SRC_PSW:   cnt_set_clr = CLK_12;
            default:   cnt_set_clr = pick_count(slow_region_i, CLK_10, CLK_12);
        endcase
    end

    wire pair_legal = (dest_pair_i == PAIR_BC) || (dest_pair_i == PAIR_DE) ||
                      (dest_pair_i == PAIR_HL);

    //////////////////////////////////////////////////////////////////////
    // Execution decision

    logic [3:0] cycles;
    // Next values for the accepted operation
    always_comb begin
        cycles       = CLK_2;
        pc_next      = pc_reg;
        opnd_next    = opnd_reg;
        opnd_we_next = opnd_we_reg;
        b_next       = b_reg;
        c_next       = c_reg;
        psw_next     = psw_reg;
        halt_next    = halt_reg;
        stop_next    = stop_reg;
        mv_ok_next   = mv_ok_reg;
        illegal_next = illegal_reg;
        if (take_req) begin
            opnd_we_next = 1'b0;
            mv_ok_next   = 1'b0;
            illegal_next = 1'b0;
            pc_next      = branch_target(instr_addr_i, LEN_2, BYTE_ZERO);
            unique case (exec_op_i)
                OP_BIT_SET: begin
                    cycles  = cnt_bit_set;
                    pc_next = branch_target(instr_addr_i, len_set,
                                            set_taken ? relative_displacement_i : BYTE_ZERO);
                end
                OP_BIT_CLEAR: begin
                    cycles  = cnt_bit_clr;
                    pc_next = branch_target(instr_addr_i, len_clear,
                                            clr_taken ? relative_displacement_i : BYTE_ZERO);
                end
                OP_SET_CLEAR: begin
                    cycles  = cnt_set_clr;
                    pc_next = branch_target(instr_addr_i, len_setclr,
                                            set_taken ? relative_displacement_i : BYTE_ZERO);
                    if (tested_bit && bit_src_i == SRC_PSW) begin
                        psw_next = cleared;
                    end else if (tested_bit) begin
                        opnd_next    = cleared;
                        opnd_we_next = 1'b1;
                    end
                end
                OP_DEC_REG: begin
                    cycles = CLK_6;
                    if (loop_reg_c_i) c_next = loop_dec;
                    else              b_next = loop_dec;
                    pc_next = branch_target(instr_addr_i, LEN_2,
                                            loop_taken ? relative_displacement_i : BYTE_ZERO);
                end
                OP_DEC_MEM: begin
                    cycles       = pick_count(slow_region_i, CLK_8, CLK_10);
                    opnd_next    = mem_dec;
                    opnd_we_next = 1'b1;
                    pc_next = branch_target(instr_addr_i, LEN_3,
                                            mem_taken ? relative_displacement_i : BYTE_ZERO);
                end
                OP_INT_ON: begin
                    cycles = CLK_6;
                    psw_next[PSW_IE_BIT] = 1'b1;
                end
                OP_INT_OFF: begin
                    cycles = CLK_6;
                    psw_next[PSW_IE_BIT] = 1'b0;
                end
                OP_HALT: begin
                    cycles    = CLK_6;
                    halt_next = 1'b1;
                end
                OP_STOP: begin
                    cycles    = CLK_6;
                    stop_next = 1'b1;
                end
                OP_WORD_MOVE: begin
                    cycles       = CLK_2;
                    mv_ok_next   = pair_legal;
                    illegal_next = !pair_legal;
                end
                default: begin
                    cycles  = CLK_2;
                    pc_next = branch_target(instr_addr_i, LEN_1, BYTE_ZERO);
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Sequencer

    assign tif.start = take_req;
    assign tif.count = cycles;
    assign state_next = take_req ? ST_RUN :
                        (tif.done ? ST_IDLE : state_reg);
    assign exec_ready_o = (state_reg == ST_IDLE) && !tif.busy && !halt_reg && !stop_reg;
    assign exec_done_o  = tif.done;

    // State register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    // Architectural results
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pc_reg      <= 16'h0000;
            opnd_reg    <= BYTE_ZERO;
            opnd_we_reg <= 1'b0;
            b_reg       <= BYTE_ZERO;
            c_reg       <= BYTE_ZERO;
            psw_reg     <= PSW_RESET;
            halt_reg    <= 1'b0;
            stop_reg    <= 1'b0;
            mv_ok_reg   <= 1'b0;
            illegal_reg <= 1'b0;
        end else if (ce_i) begin
            pc_reg      <= pc_next;
            opnd_reg    <= opnd_next;
            opnd_we_reg <= opnd_we_next;
            b_reg       <= b_next;
            c_reg       <= c_next;
            psw_reg     <= psw_next;
            halt_reg    <= halt_next;
            stop_reg    <= stop_next;
            mv_ok_reg   <= mv_ok_next;
            illegal_reg <= illegal_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Outputs

    // Registered results to pins
    assign pc_o                      = pc_reg;
    assign operand_we_o              = opnd_we_reg;
    assign operand_o                 = opnd_reg;
    assign reg_b_o                   = b_reg;
    assign reg_c_o                   = c_reg;
    assign program_status_word_o     = psw_reg;
    assign master_interrupt_enable_o = psw_reg[PSW_IE_BIT];
    assign halt_mode_o               = halt_reg;
    assign stop_mode_o               = stop_reg;
    assign word_move_accept_o        = mv_ok_reg;
    assign illegal_o                 = illegal_reg;
endmodule

// ---- bit_branch_exec_checker.sv ----
// Concurrent checks on the bit-branch execution unit ports.
// Assumes one clock domain, mclk_i, and synchronous active-high reset_i.
module bit_branch_exec_checker
    import exec_pkg::*;
(
    // Clock, reset, enable
    input wire logic                mclk_i,
    input wire logic                reset_i,
    input wire logic                ce_i,
    // Request
    input wire logic                exec_valid_i,
    input wire exec_pkg::exec_op_e  exec_op_i,
    input wire exec_pkg::bit_src_e  bit_src_i,
    input wire logic [2:0]          bit_pos_i,
    input wire logic [15:0]         instr_addr_i,
    input wire logic [7:0]          relative_displacement_i,
    input wire logic [7:0]          operand_i,
    input wire logic                loop_reg_c_i,
    input wire logic [1:0]          dest_pair_i,
    // Results
    input wire logic                exec_ready_o,
    input wire logic                exec_done_o,
    input wire logic                illegal_o,
    input wire logic [15:0]         pc_o,
    input wire logic                operand_we_o,
    input wire logic [7:0]          operand_o,
    input wire logic [7:0]          reg_b_o,
    input wire logic                master_interrupt_enable_o,
    input wire logic                halt_mode_o,
    input wire logic                stop_mode_o,
    input wire logic                word_move_accept_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Accepted request
    wire take = exec_valid_i && exec_ready_o && ce_i;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_busy;    take |=> !exec_ready_o; endproperty
    property p_pulse;   exec_done_o && ce_i |=> !exec_done_o; endproperty
    property p_reopen;  exec_done_o && ce_i && !halt_mode_o && !stop_mode_o |=> exec_ready_o; endproperty
    property p_nop;     take && exec_op_i == OP_NOP |=> (!ce_i || exec_done_o) && pc_o == $past(instr_addr_i) + 16'h0001;
    endproperty
    property p_int_six;
        take && exec_op_i inside {OP_INT_ON, OP_INT_OFF} ##1 ce_i[*4] |-> !exec_done_o ##1 (!ce_i || exec_done_o);
    endproperty
    property p_mie;
        take && exec_op_i inside {OP_INT_ON, OP_INT_OFF} |=> master_interrupt_enable_o == $past(exec_op_i == OP_INT_ON);
    endproperty
    property p_word;
        take && exec_op_i == OP_WORD_MOVE |=> word_move_accept_o == ($past(dest_pair_i) != PAIR_AX)
            && illegal_o == ($past(dest_pair_i) == PAIR_AX);
    endproperty
    property p_loop_b;
        take && exec_op_i == OP_DEC_REG && !loop_reg_c_i |=> reg_b_o == $past(reg_b_o) - BYTE_ONE
            && pc_o == $past(instr_addr_i) + LEN_2 + ((reg_b_o != BYTE_ZERO)
            ? {{8{$past(relative_displacement_i[7])}}, $past(relative_displacement_i)} : 16'h0000);
    endproperty
    property p_sfr_fall;
        take && exec_op_i == OP_BIT_SET && bit_src_i == SRC_SFR && !operand_i[bit_pos_i] |=> pc_o == $past(instr_addr_i) + LEN_4;
    endproperty
    property p_clr_wb;
        take && exec_op_i == OP_SET_CLEAR && bit_src_i != SRC_PSW && operand_i[bit_pos_i]
            |=> operand_we_o && operand_o == ($past(operand_i) & ~(8'h01 << $past(bit_pos_i)));
    endproperty
    property p_halt;
        halt_mode_o || stop_mode_o |=> $stable({halt_mode_o, stop_mode_o, pc_o}) && !exec_ready_o;
    endproperty

    a_busy:     assert property (p_busy)     else $error("ready high after accept");
    a_pulse:    assert property (p_pulse)    else $error("done longer than one cycle");
    a_reopen:   assert property (p_reopen)   else $error("ready low after done");
    a_nop:      assert property (p_nop)      else $error("no-op timing or pc wrong");
    a_int_six:  assert property (p_int_six)  else $error("interrupt op not six clocks");
    a_mie:      assert property (p_mie)      else $error("master enable wrong");
    a_word:     assert property (p_word)     else $error("word move pair check wrong");
    a_loop_b:   assert property (p_loop_b)   else $error("register loop wrong");
    a_sfr_fall: assert property (p_sfr_fall) else $error("sfr fall-through pc wrong");
    a_clr_wb:   assert property (p_clr_wb)   else $error("set-then-clear write-back wrong");
    a_halt:     assert property (p_halt)     else $error("standby not held");

    c_clr:  cover property (take && exec_op_i == OP_SET_CLEAR);
    c_mem:  cover property (take && exec_op_i == OP_DEC_MEM);
    c_halt: cover property (take && exec_op_i == OP_HALT);
endmodule

bind bit_branch_exec bit_branch_exec_checker i_checker (.mclk_i, .reset_i, .ce_i, .exec_valid_i, .exec_op_i,
    .bit_src_i, .bit_pos_i, .instr_addr_i, .relative_displacement_i, .operand_i, .loop_reg_c_i, .dest_pair_i,
    .exec_ready_o, .exec_done_o, .illegal_o, .pc_o, .operand_we_o, .operand_o, .reg_b_o,
    .master_interrupt_enable_o, .halt_mode_o, .stop_mode_o, .word_move_accept_o);

// ---- bit_branch_exec_tb_top.sv ----
// Self-checking bench for the bit-branch execution unit.
// Assumes the unit clock at 125 MHz and the checker bound to the unit.
module bit_branch_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;

    logic        mclk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, exec_valid_i = 1'b0;
    logic        slow_region_i = 1'b0, loop_reg_c_i = 1'b0;
    exec_op_e    exec_op_i = OP_NOP;
    bit_src_e    bit_src_i = SRC_SADDR;
    logic [2:0]  bit_pos_i = 3'h0;
    logic [15:0] instr_addr_i = 16'h0000, pc_o, base = 16'h0000;
    logic [7:0]  relative_displacement_i = 8'h00, operand_i = 8'h00, operand_o, reg_b_o, reg_c_o;
    logic [7:0]  program_status_word_o, psw_m = PSW_RESET, b_m = 8'h00;
    logic [1:0]  dest_pair_i = 2'h0;
    logic        exec_ready_o, exec_done_o, illegal_o, operand_we_o, master_interrupt_enable_o;
    logic        halt_mode_o, stop_mode_o, word_move_accept_o, bitv, tk, sl;
    int          miscompares = 0, checks_done = 0, n;
    int          fast_t[3][5] = '{'{8, 11, 8, 9, 10}, '{10, 11, 8, 11, 10}, '{10, 12, 8, 12, 10}};
    int          slow_t[3][2] = '{'{9, 11}, '{11, 11}, '{12, 12}};

    // 8 ns clock
    always #4 mclk_i = ~mclk_i;

    bit_branch_exec i_dut (.mclk_i, .reset_i, .ce_i, .exec_valid_i, .exec_op_i, .bit_src_i, .bit_pos_i,
        .instr_addr_i, .relative_displacement_i, .operand_i, .slow_region_i, .loop_reg_c_i, .dest_pair_i,
        .exec_ready_o, .exec_done_o, .illegal_o, .pc_o, .operand_we_o, .operand_o, .reg_b_o, .reg_c_o,
        .program_status_word_o, .master_interrupt_enable_o, .halt_mode_o, .stop_mode_o, .word_move_accept_o);

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One instruction: request, wait for done, compare count and next pc
    task automatic run(input exec_op_e op, input int n_exp, input logic [15:0] len, input logic taken,
                       input logic [7:0] disp = 8'h00, input logic [1:0] pair = 2'h1, input logic regc = 1'b0,
                       input logic [7:0] opnd = 8'h00, input bit_src_e src = SRC_SADDR,
                       input logic [2:0] pos = 3'h0, input logic slow = 1'b0, input logic stall = 1'b0);
        int cnt;
        int gap;
        cnt = 2;
        gap = 0;
        base = base + 16'h0100;
        @(posedge mclk_i);
        exec_valid_i <= 1'b1;
        exec_op_i <= op;
        bit_src_i <= src;
        bit_pos_i <= pos;
        instr_addr_i <= base;
        relative_displacement_i <= disp;
        operand_i <= opnd;
        slow_region_i <= slow;
        loop_reg_c_i <= regc;
        dest_pair_i <= pair;
        @(posedge mclk_i);
        exec_valid_i <= 1'b0;
        for (int g = 0; g < 40; g++) begin
            #1;
            if (exec_done_o === 1'b1 && ce_i === 1'b1) break;
            @(posedge mclk_i);
            if (ce_i) cnt++;
            if (stall && cnt == 3 && gap < 3) begin
                ce_i <= 1'b0;
                gap++;
            end else ce_i <= 1'b1;
        end
        if (exec_done_o !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
        check("clocks", cnt, n_exp);
        check("pc", pc_o, 16'(base + len + (taken ? {{8{disp[7]}}, disp} : 16'h0000)));
    endtask

    task automatic do_reset();
        @(posedge mclk_i);
        reset_i <= 1'b1;
        exec_valid_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        check("pc reset", pc_o, 16'h0000);
        check("psw reset", program_status_word_o, PSW_RESET);
        check("ready reset", exec_ready_o, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        run(OP_INT_ON, 6, LEN_2, 1'b0);
        check("mie on", master_interrupt_enable_o, 1'b1);
        psw_m[PSW_IE_BIT] = 1'b1;
        for (int o = 0; o < 3; o++) for (int s = 0; s < 5; s++) for (int k = 0; k < 2; k++) begin
            sl = k[0] && (s == 0 || s == 4);
            bitv = (s == 3) ? psw_m[1] : ~k[0];
            tk = (o == 1) ? !bitv : bitv;
            n = sl ? slow_t[o][s == 4] : fast_t[o][s];
            run(exec_op_e'(o + 1), n, ((o == 0) ? (s == 1) : (s < 2 || s == 3)) ? LEN_4 : LEN_3, tk,
                k ? 8'h80 : 8'h7f, 2'h1, 1'b0, k ? 8'h5a : 8'ha5, bit_src_e'(s), (s == 3) ? 3'h1 : 3'h0,
                sl, o == 2 && k == 0);
            if (o == 2 && tk && s == 3) psw_m[1] = 1'b0;
            if (o == 2 && tk && s != 3) check("write-back", {operand_we_o, operand_o}, {1'b1, 8'ha4});
            check("psw", program_status_word_o, psw_m);
        end
        $display("bit branch forms done");
        run(OP_INT_OFF, 6, LEN_2, 1'b0);
        check("mie off", master_interrupt_enable_o, 1'b0);
        run(OP_NOP, 2, 16'h0001, 1'b0);
        for (int p = 0; p < 4; p++) begin
            run(OP_WORD_MOVE, 2, LEN_2, 1'b0, 8'h00, p[1:0]);
            check("pair", {word_move_accept_o, illegal_o}, (p == 0) ? 2'b01 : 2'b10);
        end
        $display("control ops done");
        for (int i = 0; i < 256; i++) begin
            b_m = b_m - 8'h01;
            run(OP_DEC_REG, 6, LEN_2, b_m != 8'h00, 8'hfe);
            check("reg b", reg_b_o, b_m);
        end
        run(OP_DEC_REG, 6, LEN_2, 1'b1, 8'h05, 2'h1, 1'b1);
        check("reg c", reg_c_o, 8'hff);
        run(OP_DEC_MEM, 8, LEN_3, 1'b0, 8'h10, 2'h1, 1'b0, 8'h01);
        check("mem byte", {operand_we_o, operand_o}, {1'b1, 8'h00});
        run(OP_DEC_MEM, 10, LEN_3, 1'b1, 8'h10, 2'h1, 1'b0, 8'h00, SRC_SADDR, 3'h0, 1'b1);
        check("mem byte", {operand_we_o, operand_o}, {1'b1, 8'hff});
        $display("loop ops done");
        run(OP_HALT, 6, LEN_2, 1'b0);
        @(posedge mclk_i);
        exec_valid_i <= 1'b1;
        exec_op_i <= OP_NOP;
        repeat (4) @(posedge mclk_i);
        #1;
        check("halt", {halt_mode_o, exec_ready_o, pc_o}, {2'b10, base + LEN_2});
        do_reset();
        run(OP_STOP, 6, LEN_2, 1'b0);
        check("stop", {stop_mode_o, exec_ready_o}, 2'b10);
        do_reset();
        $display("standby done");
        print_verdict();
    end
endmodule
